//--- include/rmr_pkg.sv
/*
 * Shared constants for the remote module register reader.
 * Assumes nothing beyond a SystemVerilog-2012 compiler.
 */
package rmr_pkg;

	// ------------------------------------------------------------
	// Widths of the request, data and fault fields
	// ------------------------------------------------------------
	localparam int SLOT_W  = 8;
	localparam int INDEX_W = 16;
	localparam int COUNT_W = 7;
	localparam int DATA_W  = 32;
	localparam int FAULT_W = 16;

	// ------------------------------------------------------------
	// Slot ranges, word counts and buffer size
	// ------------------------------------------------------------
	localparam logic [SLOT_W-1:0]  SLOT_LEFT_FIRST  = 8'h64;
	localparam logic [SLOT_W-1:0]  SLOT_LEFT_LAST   = 8'h6B;
	localparam logic [SLOT_W-1:0]  SLOT_RIGHT_FIRST = 8'h00;
	localparam logic [SLOT_W-1:0]  SLOT_RIGHT_LAST  = 8'h07;
	localparam logic [COUNT_W-1:0] WORDS_MIN        = 7'h01;
	localparam logic [COUNT_W-1:0] WORDS_MAX        = 7'h40;
	localparam int                 DEST_DEPTH_DEF   = 64;

	// ------------------------------------------------------------
	// Fault codes and reset values
	// ------------------------------------------------------------
	localparam logic [FAULT_W-1:0] FAULT_NONE   = 16'h0000;
	localparam logic [FAULT_W-1:0] FAULT_SLOT   = 16'h0001;
	localparam logic [FAULT_W-1:0] FAULT_COUNT  = 16'h0002;
	localparam logic [FAULT_W-1:0] FAULT_DEST   = 16'h0003;
	localparam logic [FAULT_W-1:0] FAULT_MODULE = 16'h0004;
	localparam logic [DATA_W-1:0]  DATA_RESET   = 32'h0000_0000;

	// Operation states.
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_FETCH, ST_DONE, ST_FAIL} rmr_state_e;

	// True for a slot on the left side or a special slot on the right side.
	function automatic logic rmr_slot_valid(input logic [SLOT_W-1:0] slot);
		return (slot >= SLOT_LEFT_FIRST && slot <= SLOT_LEFT_LAST) ||
		       (slot >= SLOT_RIGHT_FIRST && slot <= SLOT_RIGHT_LAST);
	endfunction

endpackage

//--- logic/rmr_dest_buf.sv
/*
 * Destination array for the remote module register reader: flip-flop words
 * with one write port, a whole-array clear and a registered read port.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module rmr_dest_buf
	import rmr_pkg::*;
#(
	parameter int DEPTH = DEST_DEPTH_DEF,
	parameter int AW    = $clog2(DEPTH)
) (
	// Clock and reset.
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// Write side.
	input  wire logic              wr_en_i,
	input  wire logic [AW-1:0]     wr_addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              clr_i,
	// Read side.
	input  wire logic [AW-1:0]     rd_addr_i,
	output logic      [DATA_W-1:0] rd_data_o
);

	logic [DATA_W-1:0] mem_r   [DEPTH];
	logic [DATA_W-1:0] mem_nxt [DEPTH];
	logic [DATA_W-1:0] rd_nxt;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------

	// A clear wins over a write; both never meet because the reader clears only in ST_DONE and writes only in ST_FETCH.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
			if (clr_i) begin
				mem_nxt[i] = DATA_RESET;
			end else if (wr_en_i && wr_addr_i == AW'(i)) begin
				mem_nxt[i] = wr_data_i;
			end
		end
		rd_nxt = (int'(rd_addr_i) < DEPTH) ? mem_r[rd_addr_i] : DATA_RESET;
	end

	// Registers only.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= DATA_RESET;
			end
			rd_data_o <= DATA_RESET;
		end else begin
			mem_r     <= mem_nxt;
			rd_data_o <= rd_nxt;
		end
	end

endmodule

`default_nettype wire

//--- logic/rmr_reader.sv
/*
 * Remote module register reader: on a rising request it reads a run of
 * consecutive control registers from an extension module into a destination
 * array and reports busy, active, done, error and a fault code.
 * Assumes the side bus answers each read with one ack cycle, data alongside.
 */
// Function
// - Left side modules use slots 100 to 107.
// - Right side special modules use slots 0 to 7.
// - Slot outside both ranges gives an error.
// - Word count per read is 1 to 64.
// - Reads start at given index, then successive indices.
// - Start and capture only on request rising.
// - Busy and active rise together at start.
// - Done drops busy and active, data present.
// - Words are signed 16 or 32 bit.
// - Request fall after done clears done and data.
// - Fault raises error, code, drops busy and active.
// - Request fall after error clears error and code.
// - Successive registers go to successive destination elements.
// - Plain digital modules get no right side slot.
`timescale 1ns/100ps
`default_nettype none

module rmr_reader
	import rmr_pkg::*;
#(
	parameter int DEST_DEPTH = DEST_DEPTH_DEF,
	parameter int AW         = $clog2(DEST_DEPTH)
) (
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	// Request and its parameters.
	input  wire logic               execute_i,
	input  wire logic [SLOT_W-1:0]  module_slot_i,
	input  wire logic [INDEX_W-1:0] remote_reg_index_i,
	input  wire logic [COUNT_W-1:0] word_count_i,
	input  wire logic [AW-1:0]      dest_start_i,
	input  wire logic               dest_wide_i,
	// Status.
	output logic                    busy_o,
	output logic                    active_o,
	output logic                    done_o,
	output logic                    error_o,
	output logic      [FAULT_W-1:0] fault_code_o,
	// Side bus to the module registers.
	output logic                    rd_req_o,
	output logic      [SLOT_W-1:0]  rd_slot_o,
	output logic      [INDEX_W-1:0] rd_addr_o,
	input  wire logic               rd_ack_i,
	input  wire logic               rd_err_i,
	input  wire logic [DATA_W-1:0]  rd_data_i,
	// Destination array read port.
	input  wire logic [AW-1:0]      dest_rd_addr_i,
	output logic      [DATA_W-1:0]  dest_rd_data_o
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (DEST_DEPTH < int'(WORDS_MAX) || AW != $clog2(DEST_DEPTH)) begin : g_chk
		$error("Destination depth must hold a full run of words");
	end

	// ------------------------------------------------------------
	// Operation state
	// ------------------------------------------------------------
	rmr_state_e         state_r,  state_nxt;
	logic               exec_q_r, exec_q_nxt;
	logic [SLOT_W-1:0]  slot_r,   slot_nxt;
	logic [INDEX_W-1:0] idx_r,    idx_nxt;
	logic [COUNT_W-1:0] cnt_r,    cnt_nxt;
	logic [COUNT_W-1:0] left_r,   left_nxt;
	logic [AW-1:0]      dptr_r,   dptr_nxt;
	logic               wide_r,   wide_nxt;
	logic [FAULT_W-1:0] fault_r,  fault_nxt;
	logic               start_edge;
	logic [AW:0]        end_idx;
	logic               buf_we;
	logic               buf_clr;
	logic [DATA_W-1:0]  buf_wdata;

	assign start_edge = execute_i && !exec_q_r;
	assign end_idx    = (AW+1)'(dptr_r) + (AW+1)'(cnt_r);

	// Status and bus outputs come straight from registers; the flags and rd_req_o decode the state register.
	assign busy_o       = (state_r == ST_CHECK) || (state_r == ST_FETCH);
	assign active_o     = busy_o;
	assign done_o       = (state_r == ST_DONE);
	assign error_o      = (state_r == ST_FAIL);
	assign fault_code_o = fault_r;
	assign rd_req_o     = (state_r == ST_FETCH);
	assign rd_slot_o    = slot_r;
	assign rd_addr_o    = idx_r;

	// A narrow destination keeps the low half as a signed value.
	assign buf_we    = (state_r == ST_FETCH) && rd_ack_i && !rd_err_i;
	assign buf_wdata = wide_r ? rd_data_i : {{16{rd_data_i[15]}}, rd_data_i[15:0]};
	assign buf_clr   = (state_r == ST_DONE) && !execute_i;

	// Next-state logic. Parameters are taken only on the rising request, so a
	// caller may change them freely while the run is in flight.
	always_comb begin
		state_nxt  = state_r;
		exec_q_nxt = execute_i;
		slot_nxt   = slot_r;
		idx_nxt    = idx_r;
		cnt_nxt    = cnt_r;
		left_nxt   = left_r;
		dptr_nxt   = dptr_r;
		wide_nxt   = wide_r;
		fault_nxt  = fault_r;
		unique case (state_r)
			ST_IDLE: begin
				if (start_edge) begin
					state_nxt = ST_CHECK;
					slot_nxt  = module_slot_i;
					idx_nxt   = remote_reg_index_i;
					cnt_nxt   = word_count_i;
					left_nxt  = word_count_i;
					dptr_nxt  = dest_start_i;
					wide_nxt  = dest_wide_i;
				end
			end
			ST_CHECK: begin
				// Right side numbers count special modules only, so no gap is expected.
				if (!rmr_slot_valid(slot_r)) begin
					state_nxt = ST_FAIL;
					fault_nxt = FAULT_SLOT;
				end else if (cnt_r < WORDS_MIN || cnt_r > WORDS_MAX) begin
					state_nxt = ST_FAIL;
					fault_nxt = FAULT_COUNT;
				end else if (end_idx > (AW+1)'(DEST_DEPTH)) begin
					state_nxt = ST_FAIL;
					fault_nxt = FAULT_DEST;
				end else begin
					state_nxt = ST_FETCH;
				end
			end
			ST_FETCH: begin
				// Request edges are not looked at here, so a re-trigger is ignored.
				if (rd_ack_i) begin
					if (rd_err_i) begin
						state_nxt = ST_FAIL;
						fault_nxt = FAULT_MODULE;
					end else begin
						idx_nxt  = idx_r + 16'h0001;
						dptr_nxt = dptr_r + AW'(1);
						left_nxt = left_r - 7'h01;
						if (left_r == WORDS_MIN) begin
							state_nxt = ST_DONE;
						end
					end
				end
			end
			ST_DONE: begin
				if (!execute_i) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_FAIL: begin
				if (!execute_i) begin
					state_nxt = ST_IDLE;
					fault_nxt = FAULT_NONE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				fault_nxt = FAULT_NONE;
			end
		endcase
	end

	// Registers only.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_r  <= ST_IDLE;
			exec_q_r <= 1'b0;
			slot_r   <= SLOT_RIGHT_FIRST;
			idx_r    <= '0;
			cnt_r    <= '0;
			left_r   <= '0;
			dptr_r   <= '0;
			wide_r   <= 1'b0;
			fault_r  <= FAULT_NONE;
		end else begin
			state_r  <= state_nxt;
			exec_q_r <= exec_q_nxt;
			slot_r   <= slot_nxt;
			idx_r    <= idx_nxt;
			cnt_r    <= cnt_nxt;
			left_r   <= left_nxt;
			dptr_r   <= dptr_nxt;
			wide_r   <= wide_nxt;
			fault_r  <= fault_nxt;
		end
	end

	// ------------------------------------------------------------
	// Destination array
	// ------------------------------------------------------------
	rmr_dest_buf #(
		.DEPTH (DEST_DEPTH),
		.AW    (AW)
	) u_dest_buf (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.wr_en_i   (buf_we),
		.wr_addr_i (dptr_r),
		.wr_data_i (buf_wdata),
		.clr_i     (buf_clr),
		.rd_addr_i (dest_rd_addr_i),
		.rd_data_o (dest_rd_data_o)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	sequence s_start;
		state_r == ST_IDLE && start_edge;
	endsequence

	sequence s_last_word;
		state_r == ST_FETCH && rd_ack_i && !rd_err_i && left_r == WORDS_MIN;
	endsequence

	AST_START_BUSY: assert property (s_start |=> busy_o && active_o && !done_o && !error_o)
		else $error("Busy and active did not rise together on the request edge");

	AST_CAPTURE: assert property (s_start |=> slot_r == $past(module_slot_i) && cnt_r == $past(word_count_i))
		else $error("Request parameters not captured on the rising edge");

	AST_BAD_SLOT: assert property (state_r == ST_CHECK && !rmr_slot_valid(slot_r) |=> error_o && fault_code_o == FAULT_SLOT && !rd_req_o)
		else $error("Out of range slot did not give a slot fault");

	AST_SLOT_RANGE: assert property (rd_req_o |-> rmr_slot_valid(rd_slot_o))
		else $error("Read issued to a slot outside both ranges");

	AST_COUNT_RANGE: assert property (rd_req_o |-> cnt_r >= WORDS_MIN && cnt_r <= WORDS_MAX)
		else $error("Read issued with an illegal word count");

	AST_ADDR_STEP: assert property (state_r == ST_FETCH && rd_ack_i && !rd_err_i && left_r != WORDS_MIN
		|=> rd_req_o && rd_addr_o == $past(rd_addr_o) + 16'h0001)
		else $error("Remote index did not step by one");

	AST_DEST_STEP: assert property (buf_we |=> dptr_r == $past(dptr_r) + AW'(1))
		else $error("Destination element did not step by one");

	AST_SIGN_EXT: assert property (buf_we |-> buf_wdata[15:0] == rd_data_i[15:0] && buf_wdata[31:16] == (wide_r ? rd_data_i[31:16] : {16{rd_data_i[15]}}))
		else $error("Narrow word not sign extended");

	AST_DONE: assert property (s_last_word |=> done_o && !busy_o && !active_o)
		else $error("Done did not replace busy after the last word");

	AST_DONE_CLEAR: assert property (done_o && !execute_i ##1 1'b1 |-> !done_o ##1 dest_rd_data_o == DATA_RESET)
		else $error("Done or destination not cleared after the request fell");

	AST_ERR_RAISE: assert property ($rose(error_o) |-> !busy_o && !active_o && fault_code_o != FAULT_NONE)
		else $error("Error raised without a fault code or with busy still set");

	AST_ERR_CLEAR: assert property (error_o && !execute_i |=> !error_o && fault_code_o == FAULT_NONE)
		else $error("Error or fault code not cleared after the request fell");

	AST_NO_RETRIGGER: assert property (busy_o && start_edge |=> state_r != ST_CHECK && slot_r == $past(slot_r))
		else $error("A request edge restarted a running operation");

endmodule

`default_nettype wire

//--- verif/rmr_side_model.sv
/*
 * Behavioural model of the extension module register space on the side bus.
 * Assumes the reader holds rd_req_o until the ack of each word is taken.
 */
`timescale 1ns/100ps
`default_nettype none

module rmr_side_model
	import rmr_pkg::*;
(
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               srst_i,
	// Read request from the reader.
	input  wire logic               rd_req_i,
	input  wire logic [SLOT_W-1:0]  rd_slot_i,
	input  wire logic [INDEX_W-1:0] rd_addr_i,
	// Behaviour chosen by the bench.
	input  wire logic               slow_i,
	input  wire logic               fail_i,
	// Answer.
	output logic                    rd_ack_o,
	output logic                    rd_err_o,
	output logic      [DATA_W-1:0]  rd_data_o
);
	// ----------------------------------------------------------
	// Answer timing
	// ----------------------------------------------------------
	logic [1:0] wait_r;
	logic       fire;

	// A slow module waits three cycles, so the reader must hold its request.
	assign fire = rd_req_i && !rd_ack_o && !srst_i && (!slow_i || wait_r == 2'h3);
	assign rd_err_o = rd_ack_o & fail_i;

	// One ack strobe per word, then the wait count starts again.
	always_ff @(posedge clk_i) begin
		rd_ack_o <= fire;
		if (srst_i || !rd_req_i || rd_ack_o) begin
			wait_r <= 2'h0;
		end else if (!fire) begin
			wait_r <= wait_r + 2'h1;
		end
	end

	// Data is only good with the ack; otherwise it flips so a stale read shows.
	always_ff @(posedge clk_i) begin
		if (fire) begin
			rd_data_o <= {8'hA5, rd_slot_i, rd_addr_i};
		end else begin
			rd_data_o <= ~rd_data_o;
		end
	end

endmodule

`default_nettype wire

//--- verif/remote_module_reg_reader_test.sv
/*
 * Self-checking bench for the remote module register reader.
 * Assumes the side model file and the package are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module remote_module_reg_reader_test
	import rmr_pkg::*;
;

	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	logic               clk_i, srst_i, execute_i, dest_wide_i, slow, fail;
	logic               busy_o, active_o, done_o, error_o, rd_req, rd_ack, rd_err;
	logic [SLOT_W-1:0]  slot, rd_slot;
	logic [INDEX_W-1:0] idx, rd_addr;
	logic [COUNT_W-1:0] cnt;
	logic [5:0]         dst, dest_rd_addr;
	logic [FAULT_W-1:0] fault;
	logic [DATA_W-1:0]  rd_data, dest_rd_data;
	int                 n_fail, checks_done;

	rmr_reader dut_u (.clk_i(clk_i), .srst_i(srst_i), .execute_i(execute_i), .module_slot_i(slot),
		.remote_reg_index_i(idx), .word_count_i(cnt), .dest_start_i(dst), .dest_wide_i(dest_wide_i),
		.busy_o(busy_o), .active_o(active_o), .done_o(done_o), .error_o(error_o), .fault_code_o(fault),
		.rd_req_o(rd_req), .rd_slot_o(rd_slot), .rd_addr_o(rd_addr), .rd_ack_i(rd_ack), .rd_err_i(rd_err),
		.rd_data_i(rd_data), .dest_rd_addr_i(dest_rd_addr), .dest_rd_data_o(dest_rd_data));

	rmr_side_model side_u (.clk_i(clk_i), .srst_i(srst_i), .rd_req_i(rd_req), .rd_slot_i(rd_slot),
		.rd_addr_i(rd_addr), .slow_i(slow), .fail_i(fail), .rd_ack_o(rd_ack), .rd_err_o(rd_err),
		.rd_data_o(rd_data));

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	// Word the model holds, as the destination should store it.
	function automatic logic [DATA_W-1:0] word(input logic [SLOT_W-1:0] s, input logic [INDEX_W-1:0] i,
		input logic w);
		return w ? {8'hA5, s, i} : {{16{i[15]}}, i};
	endfunction

	task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Raise the request with its parameters; busy and active follow on the next clock.
	task automatic start(input logic [SLOT_W-1:0] s, input logic [INDEX_W-1:0] i,
		input logic [COUNT_W-1:0] c, input logic [5:0] d, input logic w);
		@(posedge clk_i);
		#1;
		slot = s;
		idx = i;
		cnt = c;
		dst = d;
		dest_wide_i = w;
		execute_i = 1'b1;
		@(posedge clk_i);
		#1;
		chk("busy", 32'h1, busy_o);
		chk("active", 32'h1, active_o);
	endtask

	// Bounded wait for done or error; busy and active must drop with it.
	task automatic wait_end(input logic want_err);
		int k;
		k = 0;
		while (done_o !== 1'b1 && error_o !== 1'b1 && k < 400) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		chk("error", 32'(want_err), error_o);
		chk("done", 32'(!want_err), done_o);
		chk("busy at end", 32'h0, busy_o);
		chk("active at end", 32'h0, active_o);
	endtask

	// Drop the request; flags and fault code clear on the next cycle.
	task automatic release_req;
		@(posedge clk_i);
		#1;
		execute_i = 1'b0;
		@(posedge clk_i);
		#1;
		chk("done cleared", 32'h0, done_o);
		chk("error cleared", 32'h0, error_o);
		chk("fault cleared", 32'h0, 32'(fault));
	endtask

	// The read port is registered, so the word shows one cycle after the address.
	task automatic peek(input logic [5:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk_i);
		#1;
		dest_rd_addr = a;
		@(posedge clk_i);
		@(posedge clk_i);
		#1;
		chk("dest word", exp, dest_rd_data);
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	// One wide word from slots 0, 7 and 100, three of the four range ends, then cleared on release.
	task automatic t_single;
		logic [SLOT_W-1:0] s[3] = '{8'h00, 8'h07, 8'h64};
		foreach (s[n]) begin
			start(s[n], 16'h0010 + 16'(n), 7'h01, 6'h00, 1'b1);
			wait_end(1'b0);
			peek(6'h00, word(s[n], 16'h0010 + 16'(n), 1'b1));
			release_req();
			peek(6'h00, 32'h0000_0000);
		end
	endtask

	// Four narrow words, slow module, index wrapping, ending on the last element.
	task automatic t_multi;
		slow = 1'b1;
		start(8'h6B, 16'hFFFE, 7'h04, 6'h3C, 1'b0);
		wait_end(1'b0);
		for (int k = 0; k < 4; k++) begin
			peek(6'h3C + 6'(k), word(8'h6B, 16'hFFFE + 16'(k), 1'b0));
		end
		release_req();
		slow = 1'b0;
	endtask

	// A fall and rise of the request during a slow run neither aborts nor restarts it.
	task automatic t_retrigger;
		slow = 1'b1;
		start(8'h02, 16'h0020, 7'h02, 6'h10, 1'b1);
		slot = 8'h05;
		idx = 16'h0100;
		execute_i = 1'b0;
		@(posedge clk_i);
		#1;
		execute_i = 1'b1;
		@(posedge clk_i);
		#1;
		chk("busy after re-trigger", 32'h1, busy_o);
		wait_end(1'b0);
		peek(6'h10, word(8'h02, 16'h0020, 1'b1));
		peek(6'h11, word(8'h02, 16'h0021, 1'b1));
		release_req();
		chk("busy after release", 32'h0, busy_o);
		slow = 1'b0;
	endtask

	// Bad slot, bad count, overrun and module failure each give their code.
	task automatic t_errors;
		logic [SLOT_W-1:0]  s[6] = '{8'h63, 8'h6C, 8'h08, 8'h00, 8'h00, 8'h00};
		logic [COUNT_W-1:0] c[6] = '{7'h01, 7'h01, 7'h01, 7'h00, 7'h41, 7'h03};
		logic [5:0]         d[6] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h3E};
		logic [FAULT_W-1:0] f[6] = '{FAULT_SLOT, FAULT_SLOT, FAULT_SLOT, FAULT_COUNT, FAULT_COUNT, FAULT_DEST};
		foreach (s[n]) begin
			start(s[n], 16'h0000, c[n], d[n], 1'b1);
			wait_end(1'b1);
			chk("fault code", 32'(f[n]), 32'(fault));
			release_req();
		end
		fail = 1'b1;
		start(8'h01, 16'h0005, 7'h02, 6'h00, 1'b1);
		wait_end(1'b1);
		chk("fault code", 32'(FAULT_MODULE), 32'(fault));
		release_req();
		fail = 1'b0;
	endtask

	// ----------------------------------------------------------
	// Clock, reset, sequence and verdict
	// ----------------------------------------------------------
	task automatic print_verdict;
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// The whole run needs under two hundred cycles; this limit of 20000 cycles leaves wide margin.
	initial begin
		#200000;
		n_fail++;
		print_verdict();
	end

	initial begin
		n_fail = 0;
		checks_done = 0;
		{srst_i, execute_i, dest_wide_i, slow, fail} = 5'b10000;
		{slot, idx, cnt, dst, dest_rd_addr} = '0;
		repeat (5) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		t_single();
		t_multi();
		t_retrigger();
		t_errors();
		print_verdict();
	end

endmodule

`default_nettype wire
